// file: rtl/srkc_pkg.sv
// Function
// - ESC T dddd CR presses a key; 0000..0009 are digit keys zero to nine.
// - Key 0100 clear, 0101 minus, 0102 decimal point, 0103 navigation, 0104 enter.
// - Key 0105 cursor up, 0106 cursor down, 0107..0110 soft keys one to four.
// - Screen class A: 0000 identification, 0100 displayed value, 0200 current position.
// - Screen 0301 error message, 0400 software id, 0800 status bar, 0900 indicators.
// - Function class F: 0000 toggles reference mode, 0002 prints measured value.
// - Special class S: 0000 resets display, 0001 locks keypad, 0002 releases it.
// - Receive buffer of 100 characters full sends XOFF to the sender.
// - Buffer drained after XOFF sends XON and accepts data again.
// - A lone STX character outputs the measured value.
// - DC3 pauses ongoing output.
// - DC1 resumes output paused by DC3.
// - ENQ requests the current error message.
// - Exported text is plain printable ASCII.
// - Raw ASCII streams only, no block transfer protocols.
// - Firmware download only on the USB bridged UART port.
// - Clear and enter held at power-on shows versions and waits for firmware.
// - Finished firmware install restarts the device to its initial screen.
// - Both serial ports accept and execute the same commands.
// - Valid key or function command gets ACK then runs; invalid gets NAK.
// - Valid screen command answers STX, text, and CR LF after each line.
// - Locked keypad ignores local keys until release or power cycle.
// - Current position is ten characters, no decimal point, leading zeros.
package srkc_pkg;
  localparam logic [7:0] C_ESC   = 8'h1B;
  localparam logic [7:0] C_CR    = 8'h0D;
  localparam logic [7:0] C_LF    = 8'h0A;
  localparam logic [7:0] C_STX   = 8'h02;
  localparam logic [7:0] C_ENQ   = 8'h05;
  localparam logic [7:0] C_ACK   = 8'h06;
  localparam logic [7:0] C_NAK   = 8'h15;
  localparam logic [7:0] C_XON   = 8'h11;
  localparam logic [7:0] C_XOFF  = 8'h13;
  localparam logic [7:0] C_ZERO  = 8'h30;
  localparam logic [7:0] C_NINE  = 8'h39;
  localparam logic [7:0] C_PLUS  = 8'h2B;
  localparam logic [7:0] C_MINUS = 8'h2D;
  localparam logic [7:0] C_ONE   = 8'h31;
  localparam logic [7:0] CL_KEY  = 8'h54;
  localparam logic [7:0] CL_SCR  = 8'h41;
  localparam logic [7:0] CL_FUN  = 8'h46;
  localparam logic [7:0] CL_SPC  = 8'h53;
  localparam logic [6:0] BUF_DEPTH = 7'h64;
  localparam logic [15:0] SC_ID   = 16'h0000;
  localparam logic [15:0] SC_DISP = 16'h0100;
  localparam logic [15:0] SC_POS  = 16'h0200;
  localparam logic [15:0] SC_ERR  = 16'h0301;
  localparam logic [15:0] SC_SWID = 16'h0400;
  localparam logic [15:0] SC_SBAR = 16'h0800;
  localparam logic [15:0] SC_STAT = 16'h0900;
  localparam logic [15:0] FN_REF   = 16'h0000;
  localparam logic [15:0] FN_PRINT = 16'h0002;
  localparam logic [15:0] SP_RST  = 16'h0000;
  localparam logic [15:0] SP_LOCK = 16'h0001;
  localparam logic [15:0] SP_FREE = 16'h0002;
  localparam logic [7:0] KEY_DIG_HI = 8'h00;
  localparam logic [7:0] KEY_FN_HI  = 8'h01;
  localparam logic [7:0] KEY_FN_MAX = 8'h10;
  localparam logic [4:0] KEY_FN_BASE = 5'h0A;
  localparam logic [2:0] TS_ID   = 3'h0;
  localparam logic [2:0] TS_DISP = 3'h1;
  localparam logic [2:0] TS_ERR  = 3'h2;
  localparam logic [2:0] TS_SWID = 3'h3;
  localparam logic [2:0] TS_SBAR = 3'h4;
  localparam logic [2:0] TS_MEAS = 3'h5;
  localparam logic [3:0] FMT_LAST = 4'h9;
  localparam logic [3:0] STAT_SET_IDX = 4'h7;
  localparam logic [3:0] STAT_REF_IDX = 4'h8;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic P_RS232 = 1'b0;
  localparam logic P_USB   = 1'b1;
  typedef enum logic [2:0] {EX_NONE, EX_KEY, EX_REF, EX_PRINT, EX_PRST, EX_LOCK, EX_FREE} srkc_exec_t;
  typedef enum logic [10:0] {
    S_BOOT  = 11'h001,
    S_IDLE  = 11'h002,
    S_CLASS = 11'h004,
    S_DIGIT = 11'h008,
    S_END   = 11'h010,
    S_REPLY = 11'h020,
    S_TXT   = 11'h040,
    S_FMT   = 11'h080,
    S_CR    = 11'h100,
    S_LF    = 11'h200,
    S_FW    = 11'h400
  } srkc_state_t;
endpackage

// file: rtl/srkc_port.sv
`timescale 1ns/1ps
`default_nettype none
module srkc_port import srkc_pkg::*; (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  output logic            tx_valid_o,
  output logic      [7:0] tx_data_o,
  input  wire logic       tx_ready_i,
  output logic            ch_valid_o,
  output logic      [7:0] ch_data_o,
  input  wire logic       ch_ready_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_data_i,
  output logic            rsp_ready_o
);
  typedef struct packed {
    logic [99:0][7:0] mem;
    logic [6:0]       wp;
    logic [6:0]       rp;
    logic [6:0]       cnt;
    logic             xoff_sent;
    logic             pend_off;
    logic             pend_on;
    logic             paused;
    logic             txv;
    logic [7:0]       txd;
  } srkc_port_t;

  srkc_port_t st_ff;
  srkc_port_t nxt_st;
  logic       push;
  logic       pop;
  logic       load;

  always_comb begin
    nxt_st = st_ff;
    // Pause controls act on arrival, so a full buffer cannot delay them
    push = rx_valid_i && rx_data_i != C_XOFF && rx_data_i != C_XON && st_ff.cnt != BUF_DEPTH;
    pop  = ch_ready_i && st_ff.cnt != 7'h00;
    if (rx_valid_i && rx_data_i == C_XOFF) begin
      nxt_st.paused = 1'b1;
    end
    if (rx_valid_i && rx_data_i == C_XON) begin
      nxt_st.paused = 1'b0;
    end
    if (push) begin
      nxt_st.mem[st_ff.wp] = rx_data_i;
      nxt_st.wp = (st_ff.wp == BUF_DEPTH - 7'h01) ? 7'h00 : st_ff.wp + 7'h01;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == BUF_DEPTH - 7'h01) ? 7'h00 : st_ff.rp + 7'h01;
    end
    nxt_st.cnt = st_ff.cnt + 7'(push) - 7'(pop);
    if (nxt_st.cnt == BUF_DEPTH && !st_ff.xoff_sent) begin
      nxt_st.pend_off  = 1'b1;
      nxt_st.xoff_sent = 1'b1;
    end
    if (nxt_st.cnt == 7'h00 && st_ff.xoff_sent) begin
      nxt_st.pend_on   = 1'b1;
      nxt_st.xoff_sent = 1'b0;
    end
    load = !st_ff.txv || tx_ready_i;
    if (st_ff.txv && tx_ready_i) begin
      nxt_st.txv = 1'b0;
    end
    // Flow characters go out even while output is paused
    if (load && st_ff.pend_off) begin
      nxt_st.txv      = 1'b1;
      nxt_st.txd      = C_XOFF;
      nxt_st.pend_off = 1'b0;
    end else if (load && st_ff.pend_on) begin
      nxt_st.txv     = 1'b1;
      nxt_st.txd     = C_XON;
      nxt_st.pend_on = 1'b0;
    end else if (load && rsp_valid_i && !st_ff.paused) begin
      nxt_st.txv = 1'b1;
      nxt_st.txd = rsp_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rsp_ready_o = load && !st_ff.pend_off && !st_ff.pend_on && !st_ff.paused;
  assign tx_valid_o  = st_ff.txv;
  assign tx_data_o   = st_ff.txd;
  assign ch_valid_o  = st_ff.cnt != 7'h00;
  assign ch_data_o   = st_ff.mem[st_ff.rp];
endmodule // srkc_port
`default_nettype wire

// file: rtl/srkc_top.sv
`timescale 1ns/1ps
`default_nettype none
module srkc_top import srkc_pkg::*; (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        rs232_rx_valid_i,
  input  wire logic  [7:0] rs232_rx_data_i,
  output logic             rs232_tx_valid_o,
  output logic       [7:0] rs232_tx_data_o,
  input  wire logic        rs232_tx_ready_i,
  input  wire logic        usb_rx_valid_i,
  input  wire logic  [7:0] usb_rx_data_i,
  output logic             usb_tx_valid_o,
  output logic       [7:0] usb_tx_data_o,
  input  wire logic        usb_tx_ready_i,
  output logic             txt_req_o,
  output logic       [2:0] txt_sel_o,
  input  wire logic        txt_valid_i,
  input  wire logic  [7:0] txt_data_i,
  input  wire logic        txt_eol_i,
  input  wire logic        txt_last_i,
  output logic             txt_ready_o,
  input  wire logic        pos_neg_i,
  input  wire logic [35:0] pos_bcd_i,
  input  wire logic  [1:0] set_state_i,
  input  wire logic        err_active_i,
  input  wire logic        local_key_valid_i,
  input  wire logic  [4:0] local_key_code_i,
  input  wire logic        hold_clr_i,
  input  wire logic        hold_enter_i,
  input  wire logic        fw_done_i,
  output logic             key_valid_o,
  output logic       [4:0] key_code_o,
  output logic             ref_mode_o,
  output logic             pos_reset_o,
  output logic             keypad_locked_o,
  output logic             fw_wait_o,
  output logic             fw_valid_o,
  output logic       [7:0] fw_data_o,
  output logic             restart_o
);
  typedef struct packed {
    srkc_state_t st;
    srkc_state_t after;
    srkc_exec_t  exec;
    logic        port;
    logic [7:0]  cls;
    logic [15:0] digs;
    logic [1:0]  dcnt;
    logic [7:0]  rbyte;
    logic [2:0]  sel;
    logic        fmt_stat;
    logic [3:0]  idx;
    logic        last;
    logic [4:0]  kcode;
    logic        locked;
    logic        ref_on;
    logic        fw;
    logic [1:0]  boot_cnt;
    logic [1:0]  clr_s;
    logic [1:0]  ent_s;
    logic        key_v;
    logic [4:0]  key_c;
    logic        prst;
    logic        fw_v;
    logic [7:0]  fw_d;
    logic        restart;
  } srkc_top_t;

  srkc_top_t st_ff;
  srkc_top_t nxt_st;

  logic [1:0]      rx_v;
  logic [1:0][7:0] rx_d;
  logic [1:0]      tx_v;
  logic [1:0][7:0] tx_d;
  logic [1:0]      tx_r;
  logic [1:0]      ch_v;
  logic [1:0][7:0] ch_d;
  logic [1:0]      pop;
  logic [1:0]      rsp_r;
  logic            rsp_v;
  logic [7:0]      rsp_d;
  logic            txt_rdy;
  logic            go_rep;
  logic [7:0]      rb;
  srkc_state_t     aft;
  srkc_exec_t      ex;
  logic [2:0]      sl;
  logic            fs;
  logic [7:0]      ch;
  logic            chv;
  logic [5:0]      kdec;

  assign rx_v = {usb_rx_valid_i, rs232_rx_valid_i};
  assign rx_d = {usb_rx_data_i, rs232_rx_data_i};
  assign tx_r = {usb_tx_ready_i, rs232_tx_ready_i};
  assign rs232_tx_valid_o = tx_v[P_RS232];
  assign rs232_tx_data_o  = tx_d[P_RS232];
  assign usb_tx_valid_o   = tx_v[P_USB];
  assign usb_tx_data_o    = tx_d[P_USB];

  // Both ports get identical front ends
  for (genvar g = 0; g < 2; g++) begin : g_port
    srkc_port u_port (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .rx_valid_i  (rx_v[g]),
      .rx_data_i   (rx_d[g]),
      .tx_valid_o  (tx_v[g]),
      .tx_data_o   (tx_d[g]),
      .tx_ready_i  (tx_r[g]),
      .ch_valid_o  (ch_v[g]),
      .ch_data_o   (ch_d[g]),
      .ch_ready_i  (pop[g]),
      .rsp_valid_i (rsp_v && st_ff.port == 1'(g)),
      .rsp_data_i  (rsp_d),
      .rsp_ready_o (rsp_r[g])
    );
  end

  function automatic logic is_digit(input logic [7:0] c);
    return c >= C_ZERO && c <= C_NINE;
  endfunction

  // Returns {valid, key code} for a four digit key frame
  function automatic logic [5:0] key_of(input logic [15:0] d);
    logic [4:0] lo;
    lo = 5'(d[7:4]) * 5'h0A + 5'(d[3:0]);
    if (d[15:8] == KEY_DIG_HI && d[7:4] == 4'h0) begin
      return {1'b1, lo};
    end else if (d[15:8] == KEY_FN_HI && d[7:0] <= KEY_FN_MAX) begin
      return {1'b1, KEY_FN_BASE + lo};
    end
    return 6'h00;
  endfunction

  // Fixed-width fields are built here, all printable characters
  function automatic logic [7:0] fmt_char(input logic stat, input logic [3:0] i, input logic neg,
                                          input logic [35:0] bcd, input logic [1:0] set, input logic rf);
    logic [7:0] c;
    c = C_ZERO;
    if (!stat) begin
      if (i == 4'h0) begin
        c = neg ? C_MINUS : C_PLUS;
      end
      for (int k = 0; k < 9; k++) begin
        if (i == 4'(k + 1)) begin
          c = C_ZERO | {4'h0, bcd[4*(8-k) +: 4]};
        end
      end
    end else if (i == STAT_SET_IDX) begin
      c = C_ZERO | {6'h00, set};
    end else if (i == STAT_REF_IDX) begin
      c = rf ? C_ONE : C_ZERO;
    end
    return c;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.key_v   = 1'b0;
    nxt_st.prst    = 1'b0;
    nxt_st.fw_v    = 1'b0;
    nxt_st.restart = 1'b0;
    nxt_st.clr_s   = {st_ff.clr_s[0], hold_clr_i};
    nxt_st.ent_s   = {st_ff.ent_s[0], hold_enter_i};
    pop     = 2'b00;
    rsp_v   = 1'b0;
    rsp_d   = C_NAK;
    txt_rdy = 1'b0;
    go_rep  = 1'b0;
    rb      = C_NAK;
    aft     = S_IDLE;
    ex      = EX_NONE;
    sl      = TS_MEAS;
    fs      = 1'b0;
    ch      = ch_d[st_ff.port];
    chv     = ch_v[st_ff.port];
    kdec    = key_of(st_ff.digs);
    if (local_key_valid_i && !st_ff.locked && !st_ff.fw) begin
      nxt_st.key_v = 1'b1;
      nxt_st.key_c = local_key_code_i;
    end
    case (st_ff.st)
      S_BOOT: begin
        if (st_ff.boot_cnt == BOOT_WAIT) begin
          if (st_ff.clr_s[1] && st_ff.ent_s[1]) begin
            nxt_st.fw = 1'b1;
            nxt_st.st = S_FW;
          end else begin
            nxt_st.st = S_IDLE;
          end
        end else begin
          nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
        end
      end
      S_FW: begin
        // Image bytes only from the USB port; RS-232 input is drained
        pop = ch_v;
        nxt_st.fw_v = ch_v[P_USB];
        nxt_st.fw_d = ch_d[P_USB];
        if (fw_done_i) begin
          nxt_st.restart = 1'b1;
          nxt_st.fw      = 1'b0;
          nxt_st.st      = S_IDLE;
        end
      end
      S_IDLE: begin
        if (chv) begin
          pop[st_ff.port] = 1'b1;
          if (ch == C_ESC) begin
            nxt_st.st = S_CLASS;
          end else if (ch == C_STX) begin
            go_rep = 1'b1;
            rb     = C_STX;
            aft    = S_TXT;
          end else if (ch == C_ENQ) begin
            go_rep = 1'b1;
            rb     = err_active_i ? C_STX : C_NAK;
            aft    = err_active_i ? S_TXT : S_IDLE;
            sl     = TS_ERR;
          end
        end else if (ch_v[!st_ff.port]) begin
          nxt_st.port = !st_ff.port;
        end
      end
      S_CLASS: begin
        if (chv) begin
          pop[st_ff.port] = 1'b1;
          if (ch == CL_KEY || ch == CL_SCR || ch == CL_FUN || ch == CL_SPC) begin
            nxt_st.cls  = ch;
            nxt_st.dcnt = 2'h0;
            nxt_st.st   = S_DIGIT;
          end else if (ch != C_ESC) begin
            go_rep = 1'b1;
          end
        end
      end
      S_DIGIT: begin
        if (chv) begin
          pop[st_ff.port] = 1'b1;
          if (is_digit(ch)) begin
            nxt_st.digs = {st_ff.digs[11:0], ch[3:0]};
            nxt_st.dcnt = st_ff.dcnt + 2'h1;
            if (st_ff.dcnt == 2'h3) begin
              nxt_st.st = S_END;
            end
          end else if (ch == C_ESC) begin
            nxt_st.st = S_CLASS;
          end else begin
            go_rep = 1'b1;
          end
        end
      end
      S_END: begin
        if (chv) begin
          pop[st_ff.port] = 1'b1;
          go_rep = 1'b1;
          if (ch == C_ESC) begin
            go_rep    = 1'b0;
            nxt_st.st = S_CLASS;
          end else if (ch == C_CR) begin
            case (st_ff.cls)
              CL_KEY: begin
                rb = kdec[5] ? C_ACK : C_NAK;
                ex = kdec[5] ? EX_KEY : EX_NONE;
              end
              CL_SCR: begin
                rb  = C_STX;
                aft = S_TXT;
                case (st_ff.digs)
                  SC_ID:   sl = TS_ID;
                  SC_DISP: sl = TS_DISP;
                  SC_POS:  aft = S_FMT;
                  SC_ERR: begin
                    sl  = TS_ERR;
                    rb  = err_active_i ? C_STX : C_NAK;
                    aft = err_active_i ? S_TXT : S_IDLE;
                  end
                  SC_SWID: sl = TS_SWID;
                  SC_SBAR: sl = TS_SBAR;
                  SC_STAT: begin
                    aft = S_FMT;
                    fs  = 1'b1;
                  end
                  default: begin
                    rb  = C_NAK;
                    aft = S_IDLE;
                  end
                endcase
              end
              CL_FUN: begin
                rb = C_ACK;
                case (st_ff.digs)
                  FN_REF:   ex = EX_REF;
                  FN_PRINT: ex = EX_PRINT;
                  default:  rb = C_NAK;
                endcase
              end
              default: begin
                rb = C_ACK;
                case (st_ff.digs)
                  SP_RST:  ex = EX_PRST;
                  SP_LOCK: ex = EX_LOCK;
                  SP_FREE: ex = EX_FREE;
                  default: rb = C_NAK;
                endcase
              end
            endcase
          end
        end
      end
      S_REPLY: begin
        rsp_v = 1'b1;
        rsp_d = st_ff.rbyte;
        if (rsp_r[st_ff.port]) begin
          // Action follows its ACK
          nxt_st.st   = st_ff.after;
          nxt_st.exec = EX_NONE;
          nxt_st.idx  = 4'h0;
          case (st_ff.exec)
            EX_KEY: begin
              nxt_st.key_v = 1'b1;
              nxt_st.key_c = st_ff.kcode;
            end
            EX_REF:  nxt_st.ref_on = !st_ff.ref_on;
            EX_PRINT: begin
              nxt_st.st    = S_REPLY;
              nxt_st.rbyte = C_STX;
              nxt_st.after = S_TXT;
              nxt_st.sel   = TS_MEAS;
            end
            EX_PRST: nxt_st.prst = 1'b1;
            EX_LOCK: nxt_st.locked = 1'b1;
            EX_FREE: nxt_st.locked = 1'b0;
            default: nxt_st.exec = EX_NONE;
          endcase
        end
      end
      S_TXT: begin
        txt_rdy = rsp_r[st_ff.port];
        rsp_v   = txt_valid_i;
        rsp_d   = txt_data_i;
        if (txt_valid_i && txt_rdy && (txt_eol_i || txt_last_i)) begin
          nxt_st.last = txt_last_i;
          nxt_st.st   = S_CR;
        end
      end
      S_FMT: begin
        rsp_v = 1'b1;
        rsp_d = fmt_char(st_ff.fmt_stat, st_ff.idx, pos_neg_i, pos_bcd_i, set_state_i, st_ff.ref_on);
        if (rsp_r[st_ff.port]) begin
          nxt_st.idx = st_ff.idx + 4'h1;
          if (st_ff.idx == FMT_LAST) begin
            nxt_st.last = 1'b1;
            nxt_st.st   = S_CR;
          end
        end
      end
      S_CR: begin
        rsp_v = 1'b1;
        rsp_d = C_CR;
        if (rsp_r[st_ff.port]) begin
          nxt_st.st = S_LF;
        end
      end
      S_LF: begin
        rsp_v = 1'b1;
        rsp_d = C_LF;
        if (rsp_r[st_ff.port]) begin
          nxt_st.st = st_ff.last ? S_IDLE : S_TXT;
        end
      end
      default: nxt_st.st = S_IDLE;
    endcase
    if (go_rep) begin
      nxt_st.st       = S_REPLY;
      nxt_st.rbyte    = rb;
      nxt_st.after    = aft;
      nxt_st.exec     = ex;
      nxt_st.sel      = sl;
      nxt_st.fmt_stat = fs;
      nxt_st.kcode    = kdec[4:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_ff       <= '0;
      st_ff.st    <= S_BOOT;
      st_ff.after <= S_IDLE;
      st_ff.exec  <= EX_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign txt_req_o       = st_ff.st == S_TXT;
  assign txt_sel_o       = st_ff.sel;
  assign txt_ready_o     = txt_rdy;
  assign key_valid_o     = st_ff.key_v;
  assign key_code_o      = st_ff.key_c;
  assign ref_mode_o      = st_ff.ref_on;
  assign pos_reset_o     = st_ff.prst;
  assign keypad_locked_o = st_ff.locked;
  assign fw_wait_o       = st_ff.fw;
  assign fw_valid_o      = st_ff.fw_v;
  assign fw_data_o       = st_ff.fw_d;
  assign restart_o       = st_ff.restart;
endmodule // srkc_top
`default_nettype wire

// file: verification/srkc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srkc_top_asserts (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       rs232_tx_valid_o,
  input wire logic [7:0] rs232_tx_data_o,
  input wire logic       rs232_tx_ready_i,
  input wire logic       usb_tx_valid_o,
  input wire logic [7:0] usb_tx_data_o,
  input wire logic       usb_tx_ready_i,
  input wire logic       txt_req_o,
  input wire logic       txt_ready_o,
  input wire logic       key_valid_o,
  input wire logic [4:0] key_code_o,
  input wire logic       pos_reset_o,
  input wire logic       fw_wait_o,
  input wire logic       fw_valid_o,
  input wire logic       restart_o
);
  default clocking cb @(posedge mclk_i); endclocking
  sequence s_rs_held;
    rs232_tx_valid_o && $stable(rs232_tx_data_o);
  endsequence
  sequence s_usb_held;
    usb_tx_valid_o && $stable(usb_tx_data_o);
  endsequence
  chk_rs_tx_hold: assert property (disable iff (!nrst_i) rs232_tx_valid_o && !rs232_tx_ready_i |=> s_rs_held)
    else $error("rs232 tx byte changed");
  chk_usb_tx_hold: assert property (disable iff (!nrst_i) usb_tx_valid_o && !usb_tx_ready_i |=> s_usb_held)
    else $error("usb tx byte changed");
  chk_boot_quiet: assert property (!nrst_i |=> !(rs232_tx_valid_o || usb_tx_valid_o || key_valid_o || fw_wait_o))
    else $error("output active after reset");
  chk_txt_gated: assert property (disable iff (!nrst_i) txt_ready_o |-> txt_req_o)
    else $error("text taken without request");
  chk_key_range: assert property (disable iff (!nrst_i) key_valid_o |-> key_code_o <= 5'h14)
    else $error("key code out of range");
  chk_pos_pulse: assert property (disable iff (!nrst_i) pos_reset_o |=> !pos_reset_o)
    else $error("display reset not a pulse");
  chk_restart_exit: assert property (disable iff (!nrst_i) restart_o |=> !restart_o && !fw_wait_o)
    else $error("restart kept firmware wait");
  chk_fw_only_wait: assert property (disable iff (!nrst_i) fw_valid_o |-> fw_wait_o)
    else $error("firmware byte outside wait mode");
endmodule // srkc_top_asserts
bind srkc_top srkc_top_asserts srkc_top_asserts_i (.*);
`default_nettype wire

// file: verification/srkc_host.sv
`timescale 1ns/1ps
`default_nettype none
module srkc_host (
  input  wire logic       mclk_i,
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] q[$];
  initial tx_ready_o = 1'b0;
  // Random back-pressure so held bytes get exercised
  always @(negedge mclk_i) tx_ready_o <= !stall_i && ($urandom % 4 != 0);
  always @(posedge mclk_i) if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
endmodule // srkc_host
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srkc_pkg::*;
  logic        mclk_i, nrst_i, rs232_rx_valid_i, usb_rx_valid_i, txt_valid_i, txt_eol_i, txt_last_i, pos_neg_i;
  logic        err_active_i, local_key_valid_i, hold_clr_i, hold_enter_i, fw_done_i, rs232_tx_ready_i;
  logic        usb_tx_ready_i, rs232_tx_valid_o, usb_tx_valid_o, txt_req_o, txt_ready_o, key_valid_o, ref_mode_o;
  logic        pos_reset_o, keypad_locked_o, fw_wait_o, fw_valid_o, restart_o, ti, stall, p;
  logic [7:0]  rs232_rx_data_i, usb_rx_data_i, rs232_tx_data_o, usb_tx_data_o, txt_data_i, fw_data_o;
  logic [7:0]  kq[$], fq[$];
  logic [15:0] sc[4] = '{SC_ID, SC_DISP, SC_SWID, SC_SBAR};
  logic [35:0] pos_bcd_i;
  logic [4:0]  local_key_code_i, key_code_o;
  logic [2:0]  txt_sel_o;
  logic [1:0]  set_state_i;
  int          fail_count, checked, pr_cnt, rs_cnt;
  srkc_top srkc_top_i (.*);
  srkc_host rs_host_i (.mclk_i, .stall_i(stall), .tx_valid_i(rs232_tx_valid_o), .tx_data_i(rs232_tx_data_o),
    .tx_ready_o(rs232_tx_ready_i));
  srkc_host usb_host_i (.mclk_i, .stall_i(1'b0), .tx_valid_i(usb_tx_valid_o), .tx_data_i(usb_tx_data_o),
    .tx_ready_o(usb_tx_ready_i));
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (key_valid_o === 1'b1) kq.push_back(8'(key_code_o));
    if (fw_valid_o === 1'b1) fq.push_back(fw_data_o);
    pr_cnt += (pos_reset_o === 1'b1);
    rs_cnt += (restart_o === 1'b1);
    if (txt_valid_i && txt_ready_o) ti <= !ti;
  end
  // Provider text is one line of two bytes
  always @(negedge mclk_i) begin
    txt_valid_i <= txt_req_o;
    txt_data_i <= ti ? 8'h42 : 8'h41;
    {txt_eol_i, txt_last_i} <= {2{ti}};
  end
  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tend(input int t);
    $display("test %0d done", t);
  endtask
  task automatic put(input bit u, input logic [7:0] b);
    @(negedge mclk_i);
    rs232_rx_valid_i = !u;
    usb_rx_valid_i = u;
    rs232_rx_data_i = b;
    usb_rx_data_i = b;
    @(negedge mclk_i);
    rs232_rx_valid_i = 0;
    usb_rx_valid_i = 0;
  endtask
  task automatic cmd(input bit u, input logic [7:0] c, input logic [15:0] n);
    put(u, C_ESC);
    put(u, c);
    for (int i = 3; i >= 0; i--) put(u, C_ZERO + 8'(n[i*4+:4]));
    put(u, C_CR);
  endtask
  task automatic rx(input bit u, input logic [7:0] e);
    repeat (500) if ((u ? usb_host_i.q.size() : rs_host_i.q.size()) == 0) @(posedge mclk_i);
    if (u) chk(usb_host_i.q.size() ? usb_host_i.q.pop_front() : 8'hXX, e);
    else chk(rs_host_i.q.size() ? rs_host_i.q.pop_front() : 8'hXX, e);
  endtask
  task automatic wk(input logic [7:0] e);
    repeat (40) if (kq.size() == 0) @(posedge mclk_i);
    chk(kq.size() ? kq.pop_front() : 8'hXX, e);
  endtask
  task automatic txt(input bit u);
    rx(u, C_STX);
    rx(u, 8'h41);
    rx(u, 8'h42);
    rx(u, C_CR);
    rx(u, C_LF);
  endtask
  task automatic lkey(input logic [4:0] c);
    repeat (3) @(negedge mclk_i);
    local_key_valid_i = 1;
    local_key_code_i = c;
    @(negedge mclk_i);
    local_key_valid_i = 0;
  endtask
  initial begin
    {nrst_i, rs232_rx_valid_i, usb_rx_valid_i, local_key_valid_i, hold_clr_i, hold_enter_i, fw_done_i} = '0;
    {stall, ti, txt_valid_i, txt_eol_i, txt_last_i, err_active_i, pos_neg_i, pos_bcd_i} = '0;
    {rs232_rx_data_i, usb_rx_data_i, txt_data_i, local_key_code_i} = '0;
    set_state_i = 2'h1;
    void'($urandom(32'h75C21299));
    repeat (20) @(negedge mclk_i);
    nrst_i = 1;
    for (int i = 0; i < 21; i++) begin
      p = 1'($urandom);
      cmd(p, CL_KEY, 16'(i < 10 ? i : 256 + (i - 10) / 10 * 16 + (i - 10) % 10));
      rx(p, C_ACK);
      wk(8'(i));
    end
    tend(1);
    put(1, 8'h5A);
    cmd(1, CL_KEY, 16'h0011);
    rx(1, C_NAK);
    cmd(0, CL_SPC, SP_LOCK);
    rx(0, C_ACK);
    lkey(5'h03);
    repeat (9) @(posedge mclk_i);
    chk(8'(kq.size()), 8'h00);
    chk(keypad_locked_o, 1'b1);
    cmd(0, CL_SPC, SP_FREE);
    rx(0, C_ACK);
    lkey(5'h07);
    wk(8'h07);
    cmd(1, CL_SPC, SP_RST);
    rx(1, C_ACK);
    repeat (9) @(posedge mclk_i);
    chk(8'(pr_cnt), 8'h01);
    tend(2);
    cmd(0, CL_FUN, FN_REF);
    rx(0, C_ACK);
    repeat (9) @(posedge mclk_i);
    chk(ref_mode_o, 1'b1);
    cmd(0, CL_FUN, FN_PRINT);
    rx(0, C_ACK);
    txt(0);
    for (int i = 0; i < 4; i++) begin
      cmd(1, CL_SCR, sc[i]);
      txt(1);
    end
    cmd(0, CL_SCR, SC_ERR);
    rx(0, C_NAK);
    put(1, C_ENQ);
    rx(1, C_NAK);
    put(0, C_STX);
    txt(0);
    pos_neg_i = 1'($urandom);
    for (int k = 0; k < 9; k++) pos_bcd_i[k*4+:4] = 4'($urandom % 10);
    cmd(0, CL_SCR, SC_POS);
    rx(0, C_STX);
    rx(0, pos_neg_i ? C_MINUS : C_PLUS);
    for (int k = 8; k >= 0; k--) rx(0, C_ZERO + 8'(pos_bcd_i[k*4+:4]));
    rx(0, C_CR);
    rx(0, C_LF);
    tend(3);
    put(0, C_XOFF);
    cmd(0, CL_KEY, 16'h0001);
    repeat (60) @(posedge mclk_i);
    chk(8'(rs_host_i.q.size()), 8'h00);
    put(0, C_XON);
    rx(0, C_ACK);
    wk(8'h01);
    // First ACK fills the stalled tx slot, second reply sticks, garbage fills buffer
    stall = 1;
    cmd(0, CL_KEY, 16'h0002);
    cmd(0, CL_KEY, 16'h0003);
    repeat (BUF_DEPTH) put(0, 8'h5A);
    @(negedge mclk_i);
    stall = 0;
    rx(0, C_ACK);
    rx(0, C_XOFF);
    rx(0, C_ACK);
    rx(0, C_XON);
    wk(8'h02);
    wk(8'h03);
    tend(4);
    @(negedge mclk_i);
    {nrst_i, hold_clr_i, hold_enter_i} = 3'b011;
    repeat (5) @(negedge mclk_i);
    nrst_i = 1;
    repeat (12) @(negedge mclk_i);
    chk(fw_wait_o, 1'b1);
    {hold_clr_i, hold_enter_i} = 2'b00;
    put(0, 8'h3C);
    put(1, 8'hA5);
    repeat (20) @(negedge mclk_i);
    chk(8'(fq.size()), 8'h01);
    chk(fq.size() ? fq[0] : 8'hXX, 8'hA5);
    fw_done_i = 1;
    @(negedge mclk_i);
    fw_done_i = 0;
    repeat (9) @(negedge mclk_i);
    chk(8'(rs_cnt), 8'h01);
    chk(fw_wait_o, 1'b0);
    tend(5);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge mclk_i);
    fail_count++;
    summarize();
  end
endmodule // tb
`default_nettype wire
